// File: common/acis_pkg.sv
/*
 package for the two-wire control slave: address, mode nibbles, sub-address
 map, field widths, reset values and states. assumes nothing beyond a SystemVerilog tool.
*/
package acis_pkg;
    localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h80;
    localparam logic [3:0] MODE_AUTO_INC = 4'h0;
    localparam logic [3:0] MODE_RENEW = 4'h8;
    localparam int VOL_W = 6;
    localparam int TONE_W = 4;
    localparam int NUM_SW = 8;
    localparam logic [3:0] SUB_VOL_L = 4'h0;
    localparam logic [3:0] SUB_VOL_R = 4'h1;
    localparam logic [3:0] SUB_VOL_C = 4'h2;
    localparam logic [3:0] SUB_TREBLE = 4'h3;
    localparam logic [3:0] SUB_BASS = 4'h4;
    localparam logic [3:0] SUB_SURROUND = 4'h5;
    localparam logic [3:0] SUB_SWITCH = 4'h6;
    localparam int SW_CENTER_MUTE = 0;
    localparam int SW_CENTER_SEL = 1;
    localparam int SW_EXT_LOGIC = 2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [VOL_W-1:0] VOL_RESET = 6'h00;
    localparam logic [TONE_W-1:0] TONE_RESET = 4'h0;
    localparam logic [NUM_SW-1:0] SW_RESET = 8'h00;
    localparam logic [3:0] SUB_RESET = 4'h0;
    typedef enum logic [2:0] {
        ACIS_IDLE, ACIS_ADDR, ACIS_SUB, ACIS_DATA, ACIS_ACK, ACIS_IGNORE
    } acis_state_e;
endpackage

// File: rtl/acis_slave.sv
/*
 write-only two-wire slave loading audio control settings.
 assumes scl and sda are asynchronous pins (bench scl period 80 ns) and a
 system clock many times faster than the serial bit rate.
*/
//
// Contract
// - answer only address byte 80 hex
// - upper nibble 0: advance sub-address per byte
// - upper nibble 8: keep same sub-address
// - message: address, sub-address, data, acks
// - start condition begins reception
// - stop condition returns to idle
// - foreign address: ignore until next start
// - pull data low on each ack clock
// - six converter settings, eight switches
// - three six-bit volumes, 00 minimum
// - treble, bass, surround four-bit codes
// - switch bit 0 off, 1 on
// - extension output follows its bit
// - center select: sum 0, input 1
`timescale 1ns/1ps
module acis_slave (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    output logic [acis_pkg::VOL_W-1:0] o_vol_left,
    output logic [acis_pkg::VOL_W-1:0] o_vol_right,
    output logic [acis_pkg::VOL_W-1:0] o_vol_center,
    output logic [acis_pkg::TONE_W-1:0] o_treble,
    output logic [acis_pkg::TONE_W-1:0] o_bass,
    output logic [acis_pkg::TONE_W-1:0] o_surround,
    output logic [acis_pkg::NUM_SW-1:0] o_switches,
    output logic o_center_mute,
    output logic o_center_in_sel,
    output logic o_extension_logic_output
);
    logic scl_m_reg;
    logic scl_s_reg;
    logic scl_d_reg;
    logic sda_m_reg;
    logic sda_s_reg;
    logic sda_d_reg;
    acis_pkg::acis_state_e state_reg;
    acis_pkg::acis_state_e after_ack_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [3:0] sub_reg;
    logic renew_reg;
    logic write_pend_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] byte_in;

    // only the second and third stages are read, for edges and framing; first stage feeds the second alone
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_m_reg <= i_scl;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= i_sda;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
        end
    end

    assign scl_rise = scl_s_reg && !scl_d_reg;
    assign scl_fall = !scl_s_reg && scl_d_reg;
    // data edges while clock high are framing; legal data moves only in clock low
    assign start_cond = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
    assign stop_cond = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
    assign byte_in = {shift_reg[6:0], sda_s_reg};

    // receive sequencer; no read branch exists, direction bit is part of the address
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            state_reg <= acis_pkg::ACIS_IDLE;
            after_ack_reg <= acis_pkg::ACIS_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            sub_reg <= acis_pkg::SUB_RESET;
            renew_reg <= 1'b0;
            write_pend_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= acis_pkg::ACIS_ADDR;
            bit_cnt_reg <= 3'h0;
            write_pend_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_reg <= acis_pkg::ACIS_IDLE;
            write_pend_reg <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            write_pend_reg <= 1'b0;
            case (state_reg)
                acis_pkg::ACIS_ADDR, acis_pkg::ACIS_SUB, acis_pkg::ACIS_DATA:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= byte_in;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == acis_pkg::BIT_LAST)
                        begin
                            state_reg <= acis_pkg::ACIS_ACK;
                            if (state_reg == acis_pkg::ACIS_ADDR)
                            begin
                                if (byte_in == acis_pkg::SLAVE_ADDR_BYTE)
                                    after_ack_reg <= acis_pkg::ACIS_SUB;
                                else
                                    state_reg <= acis_pkg::ACIS_IGNORE;
                            end
                            else if (state_reg == acis_pkg::ACIS_SUB)
                            begin
                                sub_reg <= byte_in[3:0];
                                // other upper nibbles treated as auto-increment
                                renew_reg <= (byte_in[7:4] == acis_pkg::MODE_RENEW);
                                after_ack_reg <= acis_pkg::ACIS_DATA;
                            end
                            else
                            begin
                                after_ack_reg <= acis_pkg::ACIS_DATA;
                            end
                        end
                    end
                end
                acis_pkg::ACIS_ACK:
                begin
                    // drive low from the fall after bit 8 to the fall after ack
                    if (scl_fall && !o_sda_oe)
                        o_sda_oe <= 1'b1;
                    else if (scl_fall && o_sda_oe)
                    begin
                        o_sda_oe <= 1'b0;
                        state_reg <= after_ack_reg;
                        if (after_ack_reg == acis_pkg::ACIS_DATA
                            && state_reg == acis_pkg::ACIS_ACK
                            && bit_cnt_reg == 3'h0)
                            write_pend_reg <= (after_ack_reg == acis_pkg::ACIS_DATA);
                    end
                end
                default:
                begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // track whether the byte just acked was data, not the sub-address
    logic data_byte_reg;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            data_byte_reg <= 1'b0;
        else if (start_cond)
            data_byte_reg <= 1'b0;
        else if (write_pend_reg)
            data_byte_reg <= 1'b1;
    end

    logic commit;
    assign commit = write_pend_reg && data_byte_reg;

    // sub-address pointer moves after each committed byte unless renewing
    logic [3:0] ptr_reg;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            ptr_reg <= acis_pkg::SUB_RESET;
        else if (write_pend_reg && !data_byte_reg)
            ptr_reg <= sub_reg;
        else if (commit && !renew_reg)
            ptr_reg <= ptr_reg + 4'h1;
    end

    // settings only change once the byte is acked; reset clears every setting and switch to zero
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_vol_left <= acis_pkg::VOL_RESET;
            o_vol_right <= acis_pkg::VOL_RESET;
            o_vol_center <= acis_pkg::VOL_RESET;
            o_treble <= acis_pkg::TONE_RESET;
            o_bass <= acis_pkg::TONE_RESET;
            o_surround <= acis_pkg::TONE_RESET;
            o_switches <= acis_pkg::SW_RESET;
            o_center_mute <= 1'b0;
            o_center_in_sel <= 1'b0;
            o_extension_logic_output <= 1'b0;
        end
        else if (commit)
        begin
            if (ptr_reg == acis_pkg::SUB_VOL_L)
                o_vol_left <= shift_reg[acis_pkg::VOL_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_VOL_R)
                o_vol_right <= shift_reg[acis_pkg::VOL_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_VOL_C)
                o_vol_center <= shift_reg[acis_pkg::VOL_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_TREBLE)
                o_treble <= shift_reg[acis_pkg::TONE_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_BASS)
                o_bass <= shift_reg[acis_pkg::TONE_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_SURROUND)
                o_surround <= shift_reg[acis_pkg::TONE_W-1:0];
            else if (ptr_reg == acis_pkg::SUB_SWITCH)
            begin
                o_switches <= shift_reg;
                o_center_mute <= shift_reg[acis_pkg::SW_CENTER_MUTE];
                o_center_in_sel <= shift_reg[acis_pkg::SW_CENTER_SEL];
                o_extension_logic_output <= shift_reg[acis_pkg::SW_EXT_LOGIC];
            end
        end
    end

    sequence s_foreign_addr;
        state_reg == acis_pkg::ACIS_IGNORE;
    endsequence

    AST_START_ENTERS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        start_cond |=> state_reg == acis_pkg::ACIS_ADDR)
        else $error("start did not begin address phase");
    AST_STOP_IDLES: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        stop_cond && !start_cond |=> state_reg == acis_pkg::ACIS_IDLE)
        else $error("stop did not return to idle");
    AST_IGNORE_NO_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        s_foreign_addr |-> !o_sda_oe)
        else $error("acked while ignoring foreign message");
    AST_ACK_ONLY_IN_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $rose(o_sda_oe) |-> state_reg == acis_pkg::ACIS_ACK && !scl_s_reg)
        else $error("ack driven outside ack slot");
    AST_MATCH_ACKS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        state_reg == acis_pkg::ACIS_ADDR && scl_rise && bit_cnt_reg == acis_pkg::BIT_LAST
        |=> (state_reg == acis_pkg::ACIS_ACK) == ($past(byte_in) == acis_pkg::SLAVE_ADDR_BYTE))
        else $error("address match decision wrong");
    AST_AUTO_INC: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        commit && !renew_reg |=> ptr_reg == $past(ptr_reg) + 4'h1)
        else $error("pointer did not advance");
    AST_RENEW_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        commit && renew_reg |=> $stable(ptr_reg))
        else $error("pointer moved in renewal mode");
    AST_VOL_LOAD: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        commit && ptr_reg == acis_pkg::SUB_VOL_L
        |=> o_vol_left == $past(shift_reg[acis_pkg::VOL_W-1:0]))
        else $error("left volume not loaded");
    AST_EXT_BIT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        commit && ptr_reg == acis_pkg::SUB_SWITCH
        |=> o_extension_logic_output == $past(shift_reg[acis_pkg::SW_EXT_LOGIC]))
        else $error("extension output not loaded");
endmodule

// File: dv/acis_master.sv
/*
 two-wire bus master model for the control slave: start, stop, bytes.
 assumes an open-drain data wire with pull-up resolved by the bench.
*/
`timescale 1ns/1ps
module acis_master (
    input wire logic i_clk_sys,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda,
    output logic o_ack_valid,
    output logic o_ack
);
    // clock rests high between frames, data released to the pull-up
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_ack_valid = 1'b0;
        o_ack = 1'b0;
    end
    // quarter of the 80 ns link period; the bit rate is set here only
    // bench rate runs well above the bus limit to keep runs short
    task automatic tick();
        repeat (5) @(negedge i_clk_sys);
    endtask
    // also serves as repeated start from a low clock
    task automatic start_cond();
        o_sda = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda = 1'b0;
        tick();
        o_scl = 1'b0;
        tick();
    endtask
    task automatic stop_cond();
        o_sda = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda = 1'b1;
        tick();
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            o_sda = b[i];
            tick();
            o_scl = 1'b1;
            tick();
            tick();
            o_scl = 1'b0;
            tick();
        end
        o_sda = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_ack = ~i_sda_line;
        o_ack_valid = 1'b1;
        @(negedge i_clk_sys);
        o_ack_valid = 1'b0;
        tick();
        o_scl = 1'b0;
        tick();
    endtask
endmodule

// File: dv/test_acis_slave.sv
/*
 self-checking bench for the control slave: master model writes, queues
 hold expected acks and settings. assumes settings sit in low data bits.
*/
`timescale 1ns/1ps
module test_acis_slave;
    logic i_clk_sys, i_nrst, scl, m_sda, sda_line, ack_valid, ack, o_sda_oe, snap_req;
    logic [5:0] o_vol_left, o_vol_right, o_vol_center;
    logic [3:0] o_treble, o_bass, o_surround;
    logic [7:0] o_switches;
    logic o_center_mute, o_center_in_sel, o_extension_logic_output;
    logic [7:0] shadow [0:15];
    logic exp_ack_q [$];
    logic [40:0] exp_set_q [$];
    int error_cnt, n_tests;
    assign sda_line = m_sda & ~o_sda_oe;
    acis_master acis_master_inst (.i_clk_sys(i_clk_sys), .i_sda_line(sda_line), .o_scl(scl),
        .o_sda(m_sda), .o_ack_valid(ack_valid), .o_ack(ack));
    acis_slave acis_slave_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_scl(scl),
        .i_sda(sda_line), .o_sda_oe(o_sda_oe), .o_vol_left(o_vol_left),
        .o_vol_right(o_vol_right), .o_vol_center(o_vol_center), .o_treble(o_treble),
        .o_bass(o_bass), .o_surround(o_surround), .o_switches(o_switches),
        .o_center_mute(o_center_mute), .o_center_in_sel(o_center_in_sel),
        .o_extension_logic_output(o_extension_logic_output));
    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    task automatic check(input logic [40:0] seen, input logic [40:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [40:0] expected();
        return {shadow[0][5:0], shadow[1][5:0], shadow[2][5:0], shadow[3][3:0], shadow[4][3:0],
            shadow[5][3:0], shadow[6], shadow[6][0], shadow[6][1], shadow[6][2]};
    endfunction
    always @(posedge i_clk_sys)
    begin
        if (ack_valid === 1'b1)
            check(41'(ack), 41'(exp_ack_q.pop_front()), "ack");
        if (snap_req === 1'b1)
            check({o_vol_left, o_vol_right, o_vol_center, o_treble, o_bass, o_surround, o_switches,
                o_center_mute, o_center_in_sel, o_extension_logic_output},
                exp_set_q.pop_front(), "settings");
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic snapshot();
        exp_set_q.push_back(expected());
        repeat (10) @(negedge i_clk_sys);
        snap_req = 1'b1;
        @(negedge i_clk_sys);
        snap_req = 1'b0;
    endtask
    task automatic do_reset();
        i_nrst = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        foreach (shadow[i]) shadow[i] = 8'h00;
    endtask
    // foreign address: master keeps clocking bytes that must go unanswered
    task automatic msg(input logic [7:0] addr, input logic [7:0] sub, input int n,
        input logic do_stop);
        logic hit;
        logic [7:0] d;
        logic [3:0] idx;
        hit = (addr == acis_pkg::SLAVE_ADDR_BYTE);
        acis_master_inst.start_cond();
        exp_ack_q.push_back(hit);
        acis_master_inst.send_byte(addr);
        exp_ack_q.push_back(hit);
        acis_master_inst.send_byte(sub);
        for (int k = 0; k < n; k++)
        begin
            d = 8'($urandom);
            idx = (sub[7:4] == acis_pkg::MODE_RENEW) ? sub[3:0] : 4'(sub[3:0] + 4'(k));
            if (hit)
                shadow[idx] = d;
            exp_ack_q.push_back(hit);
            acis_master_inst.send_byte(d);
        end
        if (do_stop)
            acis_master_inst.stop_cond();
        snapshot();
    endtask
    initial
    begin
        logic [7:0] sub;
        logic [7:0] addr;
        i_nrst = 1'b0;
        snap_req = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        void'($urandom(32'hf9bf4be6));
        do_reset();
        snapshot();
        msg(8'h80, 8'h00, 7, 1'b1);
        msg(8'h80, 8'h82, 3, 1'b1);
        msg(8'h81, 8'h00, 3, 1'b1);
        msg(8'h90, 8'h03, 2, 1'b1);
        msg(8'h80, 8'h05, 0, 1'b1);
        // unmapped follow-on place is acked yet changes nothing
        msg(8'h80, 8'h06, 2, 1'b0);
        msg(8'h80, 8'h80, 2, 1'b1);
        for (int r = 0; r < 10; r++)
        begin
            sub = {($urandom_range(1) != 0) ? acis_pkg::MODE_RENEW : acis_pkg::MODE_AUTO_INC,
                4'($urandom_range(6))};
            addr = ($urandom_range(4) == 0) ? 8'($urandom) : acis_pkg::SLAVE_ADDR_BYTE;
            msg(addr, sub, $urandom_range(4, 1), 1'b1);
        end
        do_reset();
        snapshot();
        msg(8'h80, 8'h01, 2, 1'b1);
        report_and_stop();
    end
    // bound on the whole run
    initial
    begin
        repeat (100000) @(posedge i_clk_sys);
        error_cnt++;
        $display("MISMATCH t=%0t run did not finish", $time);
        report_and_stop();
    end
endmodule
